// File: rtl/int_ctrl_params.svh
// register offsets, field positions, reset values and fixed figures of the interrupt controller
// assumes inclusion by the controller and the test bench only
`ifndef INT_CTRL_PARAMS_SVH
`define INT_CTRL_PARAMS_SVH
`define OFS_GLOBAL_CONTROL   12'h4D6
`define OFS_VECTOR_BASE      12'h45D
`define OFS_SOURCE_FLAG      12'h500
`define OFS_SOURCE_ENABLE    12'h504
`define OFS_PRIORITY_SELECT  12'h508
`define OFS_MODE_CONTROL     12'h50C
`define OFS_STATUS           12'h510
`define BIT_GLOBAL_HIGH      7
`define BIT_GLOBAL_LOW       6
`define BIT_PRIORITY_LEVELS  5
`define RST_GLOBAL_CONTROL   8'h07
`define RST_VECTOR_BASE      21'h000008
`define FIXED_VECTOR         21'h000008
`define VEC_SHIFT            2
`endif

// File: rtl/int_ctrl_pkg.sv
// types shared by the interrupt controller
// assumes the params header sits beside it
package int_ctrl_pkg;
  typedef struct packed
  {
    logic [7:0] ctrl;
    logic [20:0] vbase;
    logic [2:0] flag;
    logic [2:0] en;
    logic [2:0] prio;
    logic       vec_en;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [1:0] settled;
    logic       aw_full;
    logic [11:0] aw_addr;
    logic       w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic       irq_high;
    logic       irq_low;
    logic [20:0] vector;
  } ctl_state_t;
endpackage

// File: rtl/int_ctrl.sv
// global enable, priority and external edge interrupt logic behind an axi4-lite slave
// assumes external pins are asynchronous; wake-up path is pure combinational from the flag flops
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "int_ctrl_params.svh"
// ----------------------------------------------------------------------------
// Summary of operation
// - after reset every source priority bit selects high priority
// - external inputs are edge triggered; select bit one rising, zero falling
// - the selected edge sets that input's flag bit
// - enable cleared blocks the interrupt while the flag still records edges
// - an enabled external interrupt wakes the processor from idle or sleep
// - after wake-up branch to vector only if global high enable set
// - with priority enable set, each external interrupt's level comes from its own priority bit
// - wake-up request rises for any enabled event, but only while clk_en is high
// - wake-up request ignores global enables; only source enables qualify it
// - wake-up path is combinational from the flags, but pin edges set flags only while clk_en is high
// - vector table disabled means table ordering has no servicing effect
// - table and priorities both off sends every interrupt to 0008h
// - priorities off: global enable passes all enabled sources, else none
// - priorities on: global high gates high and is needed for low too
// - priorities on: global low gates low priority interrupts only
// - priorities off: global low enable reads back as zero
// - priority enable set gives two levels; cleared all are high
// ----------------------------------------------------------------------------
module int_ctrl
  import int_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // external interrupt pins
  input  wire logic [2:0]  ext_interrupt_pin,
  // cpu side
  output logic             irq_high,
  output logic             irq_low,
  output logic [20:0]      vector_addr,
  output logic             wake_request,
  // axi4-lite slave
  input  wire logic [11:0] s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [11:0] s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);
  ctl_state_t q;
  ctl_state_t next_q;
  logic       pe;
  logic [2:0] edge_hit;
  logic [2:0] pend;
  logic       wr_go;
  logic       rd_go;
  logic [7:0] ctrl_rd;
  // ----------------------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_edge
      // s3 holds the previous synchronised level, s2 the newest; s1 is read only by s2
      // no edges until the history is filled, so a pin idling high after reset is no edge
      assign edge_hit[gi] = &q.settled & (q.ctrl[gi] ? (q.s2[gi] & ~q.s3[gi])
                                                     : (~q.s2[gi] & q.s3[gi]));
    end
  endgenerate
  assign pe      = q.ctrl[`BIT_PRIORITY_LEVELS];
  assign pend    = q.flag & q.en;
  assign wr_go   = q.aw_full & q.w_full & ~q.bvalid;
  assign rd_go   = s_arvalid & ~q.rvalid;
  // global low reads zero while levels are off
  assign ctrl_rd = {q.ctrl[7], q.ctrl[6] & pe, q.ctrl[5], 2'h0, q.ctrl[2:0]};
  // ----------------------------------------------------------------------------
  // wake-up: combinational from flags and enables, no clock needed
  // ----------------------------------------------------------------------------
  assign wake_request = |pend;
  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    logic [2:0] hp;
    logic [2:0] lp;
    logic [31:0] wd;
    hp = 3'h0;
    lp = 3'h0;
    wd = 32'h0;
    next_q = q;
    next_q.s1 = ext_interrupt_pin;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    if (q.settled != 2'h3)
      next_q.settled = q.settled + 2'h1;
    // priority split
    hp = pe ? (pend & q.prio) : pend;
    lp = pe ? (pend & ~q.prio) : 3'h0;
    next_q.irq_high = q.ctrl[`BIT_GLOBAL_HIGH] & |hp;
    next_q.irq_low  = q.ctrl[`BIT_GLOBAL_HIGH] & q.ctrl[`BIT_GLOBAL_LOW] & |lp;
    // table vectoring off means one fixed address; ordering ignored
    if (!q.vec_en)
      next_q.vector = `FIXED_VECTOR;
    else if (|hp)
      next_q.vector = q.vbase + (hp[0] ? 21'h0 : hp[1] ? 21'h2 : 21'h4);
    else
      next_q.vector = q.vbase + (lp[0] ? 21'h0 : lp[1] ? 21'h2 : 21'h4);
    // write channel capture
    if (s_awvalid && !q.aw_full)
    begin
      next_q.aw_full = 1'b1;
      next_q.aw_addr = s_awaddr;
    end
    if (s_wvalid && !q.w_full)
    begin
      next_q.w_full = 1'b1;
      next_q.w_data = s_wdata;
      next_q.w_strb = s_wstrb;
    end
    // flags: the set wins over a software clear in the same cycle
    next_q.flag = q.flag;
    if (wr_go)
    begin
      wd = q.w_data;
      next_q.aw_full = 1'b0;
      next_q.w_full  = 1'b0;
      next_q.bvalid  = 1'b1;
      if (q.w_strb[0])
      begin
        unique case (q.aw_addr)
          `OFS_GLOBAL_CONTROL:  next_q.ctrl = {wd[7:5], 2'h0, wd[2:0]};
          `OFS_VECTOR_BASE:     next_q.vbase[7:0] = wd[7:0];
          `OFS_SOURCE_FLAG:     next_q.flag = wd[2:0];
          `OFS_SOURCE_ENABLE:   next_q.en = wd[2:0];
          `OFS_PRIORITY_SELECT: next_q.prio = wd[2:0];
          `OFS_MODE_CONTROL:    next_q.vec_en = wd[0];
          default:              next_q.vec_en = q.vec_en;
        endcase
      end
      if (q.aw_addr == `OFS_VECTOR_BASE && q.w_strb[1])
        next_q.vbase[15:8] = wd[15:8];
      if (q.aw_addr == `OFS_VECTOR_BASE && q.w_strb[2])
        next_q.vbase[20:16] = wd[20:16];
    end
    next_q.flag = next_q.flag | edge_hit;
    if (q.bvalid && s_bready)
      next_q.bvalid = 1'b0;
    // read channel
    if (q.rvalid && s_rready)
      next_q.rvalid = 1'b0;
    if (rd_go)
    begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = 2'h0;
      unique case (s_araddr)
        `OFS_GLOBAL_CONTROL:  next_q.rdata = {24'h0, ctrl_rd};
        `OFS_VECTOR_BASE:     next_q.rdata = {11'h0, q.vbase};
        `OFS_SOURCE_FLAG:     next_q.rdata = {29'h0, q.flag};
        `OFS_SOURCE_ENABLE:   next_q.rdata = {29'h0, q.en};
        `OFS_PRIORITY_SELECT: next_q.rdata = {29'h0, q.prio};
        `OFS_MODE_CONTROL:    next_q.rdata = {31'h0, q.vec_en};
        `OFS_STATUS:          next_q.rdata = {29'h0, q.irq_low, q.irq_high, wake_request};
        default:
        begin
          next_q.rdata = 32'h0;
          next_q.rresp = 2'h2;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      q       <= '0;
      q.ctrl  <= `RST_GLOBAL_CONTROL;
      q.vbase <= `RST_VECTOR_BASE;
      q.prio  <= 3'h7;
      q.vector <= `FIXED_VECTOR;
    end
    else if (clk_en)
      q <= next_q;
  end
  assign irq_high    = q.irq_high;
  assign irq_low     = q.irq_low;
  assign vector_addr = q.vector;
  assign s_awready   = ~q.aw_full;
  assign s_wready    = ~q.w_full;
  assign s_bvalid    = q.bvalid;
  assign s_bresp     = 2'h0;
  assign s_arready   = ~q.rvalid;
  assign s_rvalid    = q.rvalid;
  assign s_rdata     = q.rdata;
  assign s_rresp     = q.rresp;
  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || !clk_en);

  chk_flag_sticky: assert property (
    q.flag[0]
    |=> q.flag[0] || $past(wr_go))
    else $error("flag lost");

  chk_rise_flag: assert property (
    q.ctrl[0] && q.s2[0] && !q.s3[0] && (&q.settled)
    |=> q.flag[0])
    else $error("rising edge missed");

  chk_fall_flag: assert property (
    !q.ctrl[0] && !q.s2[0] && q.s3[0] && (&q.settled)
    |=> q.flag[0])
    else $error("falling edge missed");

  chk_wrong_edge: assert property (
    q.ctrl[0] && !q.s2[0] && q.s3[0] && !q.flag[0] && !wr_go
    |=> !q.flag[0])
    else $error("flag set on the other edge");

  chk_wake_en: assert property (
    q.en[0] && edge_hit[0] && !wr_go
    |=> wake_request)
    else $error("wake missing after enabled event");

  chk_masked_wake: assert property (
    q.en == 3'h0
    |-> !wake_request)
    else $error("masked wake");

  chk_gie_block: assert property (
    !q.ctrl[7]
    |=> !irq_high && !irq_low)
    else $error("irq while off");

  chk_low_gate: assert property (
    !q.ctrl[6]
    |=> !irq_low)
    else $error("low not gated");

  chk_no_levels: assert property (
    !pe
    |=> !irq_low)
    else $error("low without levels");

  chk_high_path: assert property (
    q.ctrl[7] && !pe && |pend
    |=> irq_high)
    else $error("no irq");

  chk_prio_high: assert property (
    pe && q.ctrl[7] && |(pend & q.prio)
    |=> irq_high)
    else $error("high priority request lost");

  chk_prio_low: assert property (
    pe && q.ctrl[7] && q.ctrl[6] && |(pend & ~q.prio)
    |=> irq_low)
    else $error("low priority request lost");

  chk_low_reads_zero: assert property (
    !pe
    |-> !ctrl_rd[6])
    else $error("global low visible without levels");

  chk_fixed_vec: assert property (
    !q.vec_en
    |=> vector_addr == `FIXED_VECTOR)
    else $error("vector");

  chk_table_first: assert property (
    q.vec_en && !pe && pend[0]
    |=> vector_addr == $past(q.vbase))
    else $error("table entry zero wrong");

  chk_table_second: assert property (
    q.vec_en && !pe && pend[1:0] == 2'h2
    |=> vector_addr == $past(q.vbase) + 21'h2)
    else $error("table entry one wrong");

  chk_reset_prio: assert property (
    $fell(reset)
    |-> q.prio == 3'h7)
    else $error("priority not high after reset");

  chk_hold_frozen: assert property (
    disable iff (reset)
    !clk_en |=> $stable(q))
    else $error("state moved while frozen");

  chk_write_answer: assert property (
    q.aw_full && q.w_full && !s_bvalid
    |=> s_bvalid)
    else $error("write not answered");

  chk_bvalid_hold: assert property (
    s_bvalid && !s_bready
    |=> s_bvalid)
    else $error("write response dropped");

  chk_read_answer: assert property (
    s_arvalid && s_arready
    |=> s_rvalid)
    else $error("read not answered");

  chk_rvalid_hold: assert property (
    s_rvalid && !s_rready
    |=> s_rvalid && $stable(s_rdata))
    else $error("read data not held");

  // ----------------------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------------------
  cov_high: cover property (irq_high);
  cov_low: cover property (irq_low);
  cov_wake: cover property (wake_request && !q.ctrl[7]);
  cov_table: cover property (q.vec_en && irq_high);
  cov_fall_edge: cover property (edge_hit != 3'h0 && q.ctrl[2:0] != 3'h7);
endmodule
`default_nettype wire

// File: verification/cpu_stub.sv
// cpu stand-in: takes a wake-up and branches to the offered vector
// assumes the controller's registered request and vector outputs
`timescale 1ns/1ps
`default_nettype none
module cpu_stub
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // controller requests
  input  wire logic        irq_high,
  input  wire logic        irq_low,
  input  wire logic [20:0] vector_addr,
  input  wire logic        wake_request,
  // observed branch
  output logic             taken,
  output logic [20:0]      target
);
  // branch only on a wake with a request that passed the global gates
  always_ff @(posedge clk_sys)
  begin
    taken  <= !reset && wake_request && (irq_high || irq_low);
    target <= vector_addr;
  end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench of the interrupt controller over axi4-lite
// assumes the design's offsets header and a 250 mhz clock
`timescale 1ns/1ps
`default_nettype none
`include "int_ctrl_params.svh"
module tb_top;
  logic clk_sys, reset, awv, wv, bre, arv, rre, taken, ce;
  logic [2:0] pins, e;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, rd_v;
  logic [1:0] rsp;
  logic irq_high, irq_low, wake, awr, wr_r, bv, arr, rv;
  logic [20:0] vec, target;
  int fails, n_compared;
  int_ctrl DUT (.clk_sys(clk_sys), .reset(reset), .clk_en(ce), .ext_interrupt_pin(pins),
    .irq_high(irq_high), .irq_low(irq_low), .vector_addr(vec), .wake_request(wake),
    .s_awaddr(awa), .s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(4'hF),
    .s_wvalid(wv), .s_wready(wr_r), .s_bresp(), .s_bvalid(bv), .s_bready(bre),
    .s_araddr(ara), .s_arvalid(arv), .s_arready(arr), .s_rdata(rdat), .s_rresp(rsp),
    .s_rvalid(rv), .s_rready(rre));
  cpu_stub cpu (.clk_sys(clk_sys), .reset(reset), .irq_high(irq_high), .irq_low(irq_low),
    .vector_addr(vec), .wake_request(wake), .taken(taken), .target(target));
  initial
  begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    fork
      begin do @(negedge clk_sys); while (!awr); @(posedge clk_sys); awv <= 0; end
      begin do @(negedge clk_sys); while (!wr_r); @(posedge clk_sys); wv <= 0; end
      begin do @(negedge clk_sys); while (!bv); @(posedge clk_sys); bre <= 0; end
    join
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    ara <= a; arv <= 1; rre <= 1;
    do @(negedge clk_sys); while (!arr);
    @(posedge clk_sys);
    arv <= 0;
    do @(negedge clk_sys); while (!rv);
    rd_v = rdat;
    @(posedge clk_sys);
    rre <= 0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] outs();
    return {29'h0, irq_low, irq_high, wake};
  endfunction
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {awv, wv, bre, arv, rre, pins, awa, ara, wd} = '0;
    ce = 1;
    fails = 0;
    n_compared = 0;
    reset = 1;
    void'($urandom(32'hC400));
    repeat (5) @(posedge clk_sys);
    reset <= 0;
    rd(`OFS_GLOBAL_CONTROL); chk(rd_v, 32'h07);
    rd(`OFS_PRIORITY_SELECT); chk(rd_v, 32'h7);
    rd(`OFS_VECTOR_BASE); chk(rd_v, 32'h8);
    rd(12'h0FC); chk({rd_v[29:0], rsp}, 32'h2);        // unmapped place refused
    for (int i = 0; i < 3; i++)
    begin
      e = 3'($urandom());
      if (i == 0) e = 3'h0; // falling edges on all pins
      wr(`OFS_GLOBAL_CONTROL, {24'h0, 5'h0, e});
      pins <= ~e;
      repeat (8) @(posedge clk_sys);
      wr(`OFS_SOURCE_FLAG, 0);
      pins[i] <= e[i];
      repeat (8) @(posedge clk_sys);
      rd(`OFS_SOURCE_FLAG); chk(rd_v, 32'h1 << i);
      chk(outs(), 0);
      pins[i] <= ~e[i];
      wr(`OFS_SOURCE_FLAG, 0);
      repeat (8) @(posedge clk_sys);
      rd(`OFS_SOURCE_FLAG); chk(rd_v, 0);
      pins[i] <= e[i];
      repeat (8) @(posedge clk_sys);
      wr(`OFS_PRIORITY_SELECT, 7 & ~(1 << i));
      wr(`OFS_SOURCE_ENABLE, 1 << i);
      chk(outs(), 1);
      wr(`OFS_GLOBAL_CONTROL, {24'h0, 8'h80 | e});
      chk(outs(), 3);
      chk(vec, 21'h8);
      chk({taken, target}, {1'b1, 21'h8});
      wr(`OFS_GLOBAL_CONTROL, {24'h0, 8'hA0 | e});
      chk(outs(), 1);
      wr(`OFS_GLOBAL_CONTROL, {24'h0, 8'hE0 | e});
      chk(outs(), 5);
      wr(`OFS_GLOBAL_CONTROL, {24'h0, 8'h60 | e});
      chk(outs(), 1);
      wr(`OFS_GLOBAL_CONTROL, {24'h0, 8'h40 | e});
      rd(`OFS_GLOBAL_CONTROL); chk(rd_v, e);
      wr(`OFS_SOURCE_ENABLE, 0);
      rd(`OFS_SOURCE_FLAG); chk(rd_v, 32'h1 << i);
      wr(`OFS_SOURCE_FLAG, 0);
      wr(`OFS_PRIORITY_SELECT, 7);
      pins[i] <= ~e[i];
    end
    // table vectoring: entries two apart, routines word aligned
    wr(`OFS_SOURCE_FLAG, 32'h6);
    wr(`OFS_SOURCE_ENABLE, 32'h6);
    wr(`OFS_VECTOR_BASE, 32'h3F00);
    wr(`OFS_MODE_CONTROL, 32'h1);
    wr(`OFS_GLOBAL_CONTROL, {24'h0, 8'h80 | e});
    chk(vec, 21'h3F02);
    wr(`OFS_SOURCE_ENABLE, 32'h7);
    wr(`OFS_SOURCE_FLAG, 32'h0);
    chk(outs(), 0);
    // a frozen block must not see the pin edge until it runs again
    ce <= 0;
    pins[0] <= e[0];
    repeat (8) @(posedge clk_sys);
    chk(outs(), 0);
    ce <= 1;
    repeat (8) @(posedge clk_sys);
    chk(outs(), 3);
    chk(vec, 21'h3F00);
    finish_test();
  end
  // hang guard: the whole run needs far fewer cycles than this
  initial
  begin
    #40000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
